/* abp_pkg.sv */
`default_nettype none
package abp_pkg;
  localparam int RESULT_W = 12;
  localparam int BUS_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ACQ_MODE_BIT = 5;
  localparam int HOLD_EDGES = 4;
  localparam int REF_CLK_PERIOD_NS = 10;
  localparam int INT_CLK_PERIOD_NS = 250;
  localparam int INT_CLK_CYCLES = INT_CLK_PERIOD_NS / REF_CLK_PERIOD_NS;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic DONE_N_RST = 1'b1;
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ_INT, ST_ACQ_EXT, ST_CONV} abp_state_type;
endpackage
`default_nettype wire

/* abp_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module abp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Async reset
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Not full
  input wire logic [WIDTH-1:0] i_in_data, // Write word
  output logic o_out_valid, // Not empty
  input wire logic i_out_ready, // Pop request
  output logic [WIDTH-1:0] o_out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("abp_fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      o_in_ready <= next_count != (AW+1)'(DEPTH);
      o_out_valid <= next_count != '0;
    end
  end
endmodule
`default_nettype wire

/* abp_host_port.sv */
`timescale 1ns/100ps
`default_nettype none
module abp_host_port #(
  parameter int FIFO_DEPTH = abp_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk, // 100 MHz clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_cs_n, // Chip select pin
  input wire logic i_rd_n, // Read strobe pin
  input wire logic i_wr_n, // Write strobe pin
  input wire logic i_high_byte_select, // Byte select pin
  input wire logic i_conv_clk_pin, // Converter clock pin
  input wire logic i_ext_clk_mode, // 1: use clock pin
  input wire logic [7:0] i_data, // Data pins in
  output logic [7:0] o_data, // Data pins out
  output logic o_data_oe, // Data pins driven
  output logic o_done_n, // Done pin out
  output logic o_done_oe, // Done pin driven
  output logic [7:0] o_config, // Latched configuration
  output logic o_track, // Track/hold tracking
  output logic o_convert_start, // Start conversion pulse
  input wire logic i_result_valid, // Converter result strobe
  output logic o_result_ready, // Converting and result buffer has room
  input wire logic [11:0] i_result // Converter result
);
  localparam int NB = 13;
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("abp_host_port needs a result buffer of at least 2");
  end

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers with agreement filter
  logic [NB-1:0] pin_raw;
  logic [NB-1:0] sync1;
  logic [NB-1:0] sync2;
  logic [NB-1:0] sync3;
  logic [NB-1:0] filt;
  logic [NB-1:0] filt_d;
  assign pin_raw = {i_conv_clk_pin, i_high_byte_select, i_wr_n, i_rd_n, i_cs_n, i_data};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  for (genvar b = 0; b < NB; b++) begin : g_filt
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        filt[b] <= 1'b1;
        filt_d[b] <= 1'b1;
      end else begin
        if (sync2[b] == sync3[b]) filt[b] <= sync2[b];
        filt_d[b] <= filt[b];
      end
    end
  end

  logic [7:0] data_f;
  logic cs_f;
  logic hbs_f;
  logic rd_fall;
  logic rd_rise;
  logic wr_rise;
  logic pin_clk_fall;
  assign data_f = filt[7:0];
  assign cs_f = filt[8];
  assign hbs_f = filt[11];
  assign rd_fall = filt_d[9] && !filt[9] && !cs_f;
  assign rd_rise = !filt_d[9] && filt[9] && !cs_f;
  assign wr_rise = !filt_d[10] && filt[10] && !cs_f;
  assign pin_clk_fall = filt_d[12] && !filt[12];

  ////////////////////////////////////////////////////////////////
  // Internal converter clock as enable pulse
  logic [$clog2(abp_pkg::INT_CLK_CYCLES)-1:0] div_cnt;
  logic int_clk_fall;
  logic conv_fall;
  assign int_clk_fall = div_cnt == '0;
  assign conv_fall = i_ext_clk_mode ? pin_clk_fall : int_clk_fall;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= '0;
    end else if (int_clk_fall) begin
      div_cnt <= ($bits(div_cnt))'(abp_pkg::INT_CLK_CYCLES - 1);
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Acquisition and conversion sequence
  abp_pkg::abp_state_type state;
  logic [1:0] edge_cnt;
  logic fifo_in_ready;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= abp_pkg::ST_IDLE;
      edge_cnt <= '0;
      o_config <= abp_pkg::CONFIG_RST;
      o_track <= 1'b0;
      o_convert_start <= 1'b0;
    end else begin
      o_convert_start <= 1'b0;
      case (state)
        abp_pkg::ST_IDLE: begin
          // Full buffer stalls new starts
          if (wr_rise && fifo_in_ready) begin
            o_config <= data_f;
            o_track <= 1'b1;
            edge_cnt <= '0;
            if (data_f[abp_pkg::ACQ_MODE_BIT]) begin
              state <= abp_pkg::ST_ACQ_EXT;
            end else begin
              state <= abp_pkg::ST_ACQ_INT;
            end
          end
        end
        abp_pkg::ST_ACQ_INT: begin
          if (conv_fall) begin
            edge_cnt <= edge_cnt + 1'b1;
            if (edge_cnt == 2'(abp_pkg::HOLD_EDGES - 1)) begin
              o_track <= 1'b0;
              o_convert_start <= 1'b1;
              state <= abp_pkg::ST_CONV;
            end
          end
        end
        abp_pkg::ST_ACQ_EXT: begin
          if (wr_rise) begin
            o_track <= 1'b0;
            o_convert_start <= 1'b1;
            state <= abp_pkg::ST_CONV;
          end
        end
        abp_pkg::ST_CONV: begin
          // Writes ignored until the result is buffered
          if (i_result_valid && fifo_in_ready) begin
            state <= abp_pkg::ST_IDLE;
          end
        end
        default: state <= abp_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Result buffer
  logic head_valid;
  logic [11:0] head;
  logic pop;
  logic read_seen;
  assign pop = rd_rise && hbs_f && read_seen;

  abp_fifo #(
    .WIDTH(abp_pkg::RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(i_result_valid && state == abp_pkg::ST_CONV),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_result),
    .o_out_valid(head_valid),
    .i_out_ready(pop),
    .o_out_data(head)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_result_ready <= 1'b0;
    end else begin
      o_result_ready <= fifo_in_ready && state == abp_pkg::ST_CONV;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Done flag and read bus
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      read_seen <= 1'b0;
    end else if (rd_fall && head_valid) begin
      read_seen <= 1'b1;
    end else if (pop) begin
      read_seen <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done_n <= abp_pkg::DONE_N_RST;
      o_done_oe <= 1'b0;
    end else begin
      o_done_oe <= !cs_f;
      o_done_n <= !(head_valid && !read_seen && !rd_fall);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= '0;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= !cs_f && !filt[9];
      // Empty buffer shows zeros, never stale memory
      if (!head_valid) begin
        o_data <= '0;
      end else if (hbs_f) begin
        o_data <= {4'h0, head[11:8]};
      end else begin
        o_data <= head[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_high_byte_top: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hbs_f |=> o_data[7:4] == 4'h0)
    else $error("upper lines not zero in high byte");
  a_nibble_order: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    1'b1 |=> o_data[3:0] == (!$past(head_valid) ? 4'h0 : $past(hbs_f) ? $past(head[11:8]) : $past(head[3:0])))
    else $error("low data lines carry wrong result bits");
  a_done_ready: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    head_valid && !read_seen && !rd_fall |=> !o_done_n)
    else $error("done not asserted for ready result");
  a_read_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    rd_fall |=> o_data_oe)
    else $error("read strobe did not drive bus");
  a_config_latch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == abp_pkg::ST_IDLE && wr_rise && fifo_in_ready |=> o_config == $past(data_f) && o_track)
    else $error("configuration not latched on write");
  a_ext_start: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == abp_pkg::ST_ACQ_EXT && wr_rise |=> o_convert_start && !o_track)
    else $error("external acquisition did not start conversion");
  a_float_cs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cs_f |=> !o_data_oe && !o_done_oe)
    else $error("pins driven with chip select high");
  a_track_begin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == abp_pkg::ST_IDLE && wr_rise && fifo_in_ready |=> o_track [*2])
    else $error("tracking did not begin");
  a_hold_fourth: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_convert_start && $past(state) == abp_pkg::ST_ACQ_INT |-> $past(edge_cnt) == 2'd3)
    else $error("hold not on fourth clock fall");
  a_done_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    rd_fall |=> o_done_n)
    else $error("read did not release done");
endmodule
`default_nettype wire

/* abp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module abp_host_model (
  input wire logic i_ref_clk, // Clock
  input wire logic i_ext_clk_mode, // Clock pin runs
  input wire logic [7:0] i_bus, // Data pins seen
  output logic o_cs_n, // Chip select
  output logic o_rd_n, // Read strobe
  output logic o_wr_n, // Write strobe
  output logic o_hbs, // Byte select
  output logic o_clk_pin, // Converter clock
  output logic [7:0] o_data // Data driven
);
  logic [3:0] div = 4'h0;
  initial {o_cs_n, o_rd_n, o_wr_n, o_hbs, o_clk_pin, o_data} = {5'h1c, 8'h00};
  // Free running in external mode, tied low otherwise
  always @(posedge i_ref_clk) begin
    div <= div + 4'h1;
    o_clk_pin <= i_ext_clk_mode & div[3];
  end
  task automatic pins(input logic cs, input logic rd, input logic wr, input logic hb);
    @(posedge i_ref_clk);
    {o_cs_n, o_rd_n, o_wr_n, o_hbs} <= {cs, rd, wr, hb};
    repeat (8) @(posedge i_ref_clk);
  endtask
  task automatic write(input logic [7:0] cfg);
    @(posedge i_ref_clk);
    o_data <= cfg;
    pins(0, 1, 1, 0);
    pins(0, 1, 0, 0);
    pins(0, 1, 1, 0);
    o_data <= ~cfg;
    pins(1, 1, 1, 0);
  endtask
  task automatic read(input logic hb, output logic [7:0] b);
    pins(0, 1, 1, hb);
    pins(0, 0, 1, hb);
    b = i_bus;
    pins(0, 1, 1, hb);
    pins(1, 1, 1, hb);
  endtask
endmodule
`default_nettype wire

/* abp_host_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module abp_host_port_tb;
  logic clk = 0;
  logic rst = 1;
  logic ext = 0;
  logic rv = 0;
  logic [11:0] res = 12'h000;
  logic cs_n, rd_n, wr_n, hbs, cpin, oe, done_n, done_oe, track, cstart, rready;
  logic [7:0] hdata, dout, cfg, bus, b;
  int n_errors = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  assign bus = oe ? dout : 8'hzz;
  abp_host_model host (.i_ref_clk(clk), .i_ext_clk_mode(ext), .i_bus(bus), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_hbs(hbs), .o_clk_pin(cpin), .o_data(hdata));
  abp_host_port uut (.i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_high_byte_select(hbs), .i_conv_clk_pin(cpin), .i_ext_clk_mode(ext), .i_data(hdata), .o_data(dout),
    .o_data_oe(oe), .o_done_n(done_n), .o_done_oe(done_oe), .o_config(cfg), .o_track(track),
    .o_convert_start(cstart), .i_result_valid(rv), .o_result_ready(rready), .i_result(res));
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic waitv(input int k, input logic v);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if ((k == 0 ? cstart : k == 1 ? rready : done_n) === v) return;
    end
    n_errors++;
    stop_test;
  endtask
  task automatic conv(input logic [11:0] r);
    waitv(1, 1);
    @(posedge clk);
    rv <= 1;
    res <= r;
    @(posedge clk);
    rv <= 0;
    waitv(2, 0);
  endtask
  task automatic rdword(input logic [11:0] w);
    host.read(0, b);
    chk(b, w[7:0]);
    chk(done_n, 1);
    host.read(1, b);
    chk(b, {4'h0, w[11:8]});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({done_n, oe, done_oe, track, rready, cstart}, 12'h020);
    chk(cfg, 12'h000);
  endtask
  task automatic t_float;
    host.pins(1, 0, 1, 0);
    chk({oe, done_oe}, 12'h000);
    host.pins(0, 1, 1, 0);
    chk(done_oe, 1);
    host.pins(1, 1, 1, 0);
    chk(done_oe, 0);
  endtask
  task automatic t_internal;
    host.write(8'h1a);
    chk(cfg, 8'h1a);
    chk(track, 1);
    repeat (60) @(posedge clk);
    chk(track, 1);
    waitv(0, 1);
    chk(track, 0);
    conv(12'h5c3);
    rdword(12'h5c3);
    chk(done_n, 1);
  endtask
  task automatic t_fifo;
    int i;
    ext <= 1;
    for (i = 0; i < 9; i++) begin
      host.write(8'h20);
      chk(track, i < 8);
      if (i == 0) begin
        repeat (100) @(posedge clk);
        chk(track, 1);
      end
      if (i < 8) begin
        host.write(8'h20);
        chk(track, 0);
        conv({i[3:0], i[7:0] ^ 8'ha5});
      end
    end
    chk(rready, 0);
    for (i = 0; i < 8; i++) begin
      chk(done_n, 0);
      rdword({i[3:0], i[7:0] ^ 8'ha5});
    end
    chk(done_n, 1);
  endtask
  task automatic t_extclk;
    host.write(8'h0a);
    chk(cfg, 8'h0a);
    chk(track, 1);
    repeat (56) @(posedge clk);
    chk(track, 0);
    conv(12'h3e7);
    rdword(12'h3e7);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (8) @(posedge clk);
    t_reset;
    t_float;
    t_internal;
    t_fifo;
    t_extclk;
    stop_test;
  end
endmodule
`default_nettype wire
